// file: hdl/tpc_top.sv
/*
  Timer and PWM top: APB register file, clock source choice,
  prescaler, sixteen-bit main counter, overflow flag and channels.
  Assumes one 200 MHz core clock; pins are asynchronous to it.
*/
`timescale 1ns/10ps
module tpc_top (
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       ext_clk_pin,
  input  wire logic                       fixed_clk,
  input  wire logic                       loop_engaged,
  input  wire logic                       debug_halt_mode,
  input  wire logic [tpc_pkg::TPC_NCH-1:0] ch_pin_in,
  output logic      [tpc_pkg::TPC_NCH-1:0] ch_pin_out,
  output logic      [tpc_pkg::TPC_NCH-1:0] ch_pin_oe,
  output logic                            irq
);
  import tpc_pkg::*;

  typedef struct packed {
    logic [1:0]       css;
    logic [2:0]       ps;
    logic             cas;
    logic [TPC_NCH:0] mask;
    logic [15:0]      modv;
    logic [15:0]      cnt;
    logic [6:0]       pre;
    logic             up;
    logic             counter_overflow_flag;
    logic             tof_arm;
    logic             ext_q;
    logic             fix_q;
    logic [31:0]      rdata;
    logic             err;
  } tpc_top_st_t;
  tpc_top_st_t s, next_s;

  logic [TPC_NCH+1:0] sync_q;
  logic               ext_s, fix_s, ext_rise, fix_rise;
  logic [TPC_NCH-1:0] ch_s;

  logic               setup, wr, rd;
  logic               hit_ctrl, hit_stat, hit_mask, hit_cnt, hit_mod;
  logic [TPC_NCH-1:0] hit_chc, hit_chv;
  logic               mapped;
  logic [31:0]        rd_word;

  tpc_src_t           src;
  logic               src_tick, div_tick, adv, cnt_clr, tof_set;
  logic [6:0]         pmask;
  logic [15:0]        limit, cnt_next;
  logic               up_next;

  logic [3:0]         ch_ctrl [TPC_NCH];
  logic [15:0]        ch_val [TPC_NCH];
  logic [15:0]        ch_wval [TPC_NCH];
  logic [TPC_NCH-1:0] ch_flag, ch_wrc, ch_wrv, ch_arm, ch_wr0;

  // Byte-lane merge for a 16-bit register
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [1:0]  strb
  );
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  // Pins pass two flops before any logic sees them
  tpc_sync #(
    .W (TPC_NCH + 2)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .d        ({ch_pin_in, fixed_clk, ext_clk_pin}),
    .q        (sync_q)
  );

  assign ext_s    = sync_q[0];
  assign fix_s    = sync_q[1];
  assign ch_s     = sync_q[TPC_NCH+1:2];
  assign ext_rise = ext_s && !s.ext_q;
  assign fix_rise = fix_s && !s.fix_q;

  // Zero-wait slave: data is fetched in the setup cycle
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite;
  assign rd     = psel && penable && !pwrite;
  assign pready = 1'b1;

  assign hit_ctrl = paddr == TPC_CTRL;
  assign hit_stat = paddr == TPC_STAT;
  assign hit_mask = paddr == TPC_MASK;
  assign hit_cnt  = paddr == TPC_CNT;
  assign hit_mod  = paddr == TPC_MOD;

  always_comb begin
    for (int i = 0; i < TPC_NCH; i++) begin
      hit_chc[i] = paddr == 8'(TPC_CH_BASE + i * TPC_CH_STEP);
      hit_chv[i] = paddr ==
                   8'(TPC_CH_BASE + i * TPC_CH_STEP + TPC_CH_VALOFS);
    end
  end

  assign mapped = hit_ctrl || hit_stat || hit_mask || hit_cnt ||
                  hit_mod || (|hit_chc) || (|hit_chv);

  always_comb begin
    rd_word = '0;
    if (hit_ctrl) begin
      rd_word[TPC_CTRL_CSS_LSB+:2] = s.css;
      rd_word[TPC_CTRL_PS_LSB+:3]  = s.ps;
      rd_word[TPC_CTRL_CAS_BIT]    = s.cas;
    end
    if (hit_stat) begin
      rd_word[TPC_STAT_TOF_BIT]            = s.counter_overflow_flag;
      rd_word[TPC_STAT_CH_LSB+:TPC_NCH]    = ch_flag;
    end
    if (hit_mask) begin
      rd_word[TPC_NCH:0] = s.mask;
    end
    if (hit_cnt) begin
      // Count stands still in debug halt, so this is the frozen value
      rd_word[15:0] = s.cnt;
    end
    if (hit_mod) begin
      rd_word[15:0] = s.modv;
    end
    for (int i = 0; i < TPC_NCH; i++) begin
      if (hit_chc[i]) begin
        rd_word[3:0] = ch_ctrl[i];
      end
      if (hit_chv[i]) begin
        rd_word[15:0] = ch_val[i];
      end
    end
  end

  // Clock source to prescaler input
  assign src = tpc_src_t'(s.css);

  always_comb begin
    unique case (src)
      TPC_SRC_NONE:  src_tick = 1'b0;
      TPC_SRC_BUS:   src_tick = 1'b1;
      // Unlocked fixed clock equals the bus clock, no sync stage
      TPC_SRC_FIXED: src_tick = loop_engaged ? fix_rise : 1'b1;
      TPC_SRC_EXT:   src_tick = ext_rise;
    endcase
  end

  assign cnt_clr  = wr && hit_cnt && (pstrb[0] || pstrb[1]);
  assign pmask    = 7'((7'h01 << s.ps) - 7'h01);
  assign div_tick = src_tick && !debug_halt_mode &&
                    ((s.pre & pmask) == pmask);
  assign adv      = div_tick && !cnt_clr;
  assign limit    = (s.modv == TPC_MOD_RST) ? TPC_CNT_TOP : s.modv;

  // Next count value and direction
  always_comb begin
    cnt_next = s.cnt;
    up_next  = s.up;
    tof_set  = 1'b0;
    if (cnt_clr) begin
      cnt_next = TPC_CNT_RST;
      up_next  = 1'b1;
    end else if (adv) begin
      if (!s.cas) begin
        if (s.cnt == limit) begin
          cnt_next = TPC_CNT_RST;
          tof_set  = 1'b1;
        end else begin
          cnt_next = s.cnt + 16'h0001;
        end
      end else if (s.up) begin
        // Turn down at the modulus; the period ends here
        if (s.cnt >= limit) begin
          cnt_next = s.cnt - 16'h0001;
          up_next  = 1'b0;
          tof_set  = 1'b1;
        end else begin
          cnt_next = s.cnt + 16'h0001;
        end
      end else if (s.cnt == TPC_CNT_RST) begin
        cnt_next = s.cnt + 16'h0001;
        up_next  = 1'b1;
      end else begin
        cnt_next = s.cnt - 16'h0001;
      end
    end
  end

  // Per-channel strobes from the bus
  always_comb begin
    for (int i = 0; i < TPC_NCH; i++) begin
      ch_wrc[i]  = wr && hit_chc[i] && pstrb[0];
      ch_wrv[i]  = wr && hit_chv[i] && (pstrb[0] || pstrb[1]);
      ch_wval[i] = hit_chc[i] ? pwdata[15:0] :
                   merge16(ch_val[i], pwdata[15:0], pstrb[1:0]);
      // Arm only on a one that the read really returned
      ch_arm[i]  = rd && hit_stat && s.rdata[TPC_STAT_CH_LSB + i];
      ch_wr0[i]  = wr && hit_stat && pstrb[0] &&
                   !pwdata[TPC_STAT_CH_LSB + i];
    end
  end

  genvar g;
  generate
    for (g = 0; g < TPC_NCH; g++) begin : gen_ch
      tpc_channel u_ch (
        .core_clk (core_clk),
        .reset    (reset),
        .cnt      (s.cnt),
        .cnt_next (cnt_next),
        .adv      (adv),
        .center   (s.cas),
        .pin_s    (ch_s[g]),
        .wr_ctrl  (ch_wrc[g]),
        .wr_val   (ch_wrv[g]),
        .wdata    (ch_wval[g]),
        .arm_rd   (ch_arm[g]),
        .wr_zero  (ch_wr0[g]),
        .ctrl     (ch_ctrl[g]),
        .val      (ch_val[g]),
        .flag     (ch_flag[g]),
        .pin_out  (ch_pin_out[g]),
        .pin_oe   (ch_pin_oe[g])
      );
    end
  endgenerate

  always_comb begin
    next_s       = s;
    next_s.ext_q = ext_s;
    next_s.fix_q = fix_s;
    next_s.cnt   = cnt_next;
    next_s.up    = up_next;
    if (cnt_clr) begin
      next_s.pre = TPC_PRE_RST;
    end else if (src_tick && !debug_halt_mode) begin
      next_s.pre = s.pre + 7'h01;
    end
    if (setup) begin
      next_s.rdata = pwrite ? 32'h0000_0000 : rd_word;
      next_s.err   = !mapped;
    end
    if (wr && hit_ctrl && pstrb[0]) begin
      next_s.css = pwdata[TPC_CTRL_CSS_LSB+:2];
      next_s.ps  = pwdata[TPC_CTRL_PS_LSB+:3];
      next_s.cas = pwdata[TPC_CTRL_CAS_BIT];
    end
    if (wr && hit_mask && pstrb[0]) begin
      next_s.mask = pwdata[TPC_NCH:0];
    end
    if (wr && hit_mod) begin
      next_s.modv = merge16(s.modv, pwdata[15:0], pstrb[1:0]);
    end
    // Set wins over a clear in the same cycle
    if (tof_set) begin
      next_s.counter_overflow_flag = 1'b1;
    end else if (wr && hit_stat && pstrb[0] && s.tof_arm &&
                 !pwdata[TPC_STAT_TOF_BIT]) begin
      next_s.counter_overflow_flag = 1'b0;
    end
    // Flag set at the setup edge was not seen, so it stays unarmed
    if (rd && hit_stat) begin
      next_s.tof_arm = s.rdata[TPC_STAT_TOF_BIT];
    end else if (wr && hit_stat && pstrb[0]) begin
      next_s.tof_arm = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s      <= '0;
      s.css  <= TPC_CSS_RST;
      s.ps   <= TPC_PS_RST;
      s.modv <= TPC_MOD_RST;
      s.cnt  <= TPC_CNT_RST;
      s.pre  <= TPC_PRE_RST;
      s.up   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.rdata;
  assign pslverr = s.err;
  // Level output, no pulse stretching
  assign irq = |({ch_flag, s.counter_overflow_flag} & s.mask);

  chk_stop_hold: assert property (@(posedge core_clk)
    disable iff (reset)
    (s.css == TPC_SRC_NONE && !cnt_clr) |=> s.cnt == $past(s.cnt)
  ) else $error("counter moved with no clock selected");

  chk_bus_direct: assert property (@(posedge core_clk)
    disable iff (reset)
    (s.css == TPC_SRC_BUS && s.ps == 3'h0 && !debug_halt_mode &&
     !cnt_clr && !s.cas && s.cnt != limit)
    |=> s.cnt == $past(s.cnt) + 16'h0001
  ) else $error("bus clock source did not count every cycle");

  chk_fixed_sync: assert property (@(posedge core_clk)
    disable iff (reset)
    (s.css == TPC_SRC_FIXED && loop_engaged && !fix_rise) |-> !src_tick
  ) else $error("engaged fixed clock ticked without synced edge");

  chk_ext_sync: assert property (@(posedge core_clk)
    disable iff (reset)
    (s.css == TPC_SRC_EXT) |-> (src_tick == (ext_s && !s.ext_q))
  ) else $error("external tick not from synced rising edge");

  chk_irq_level: assert property (@(posedge core_clk)
    disable iff (reset)
    (s.counter_overflow_flag && s.mask[0]) |-> irq
  ) else $error("overflow interrupt missing");

  chk_free_wrap: assert property (@(posedge core_clk)
    disable iff (reset)
    (adv && !s.cas && s.modv == TPC_MOD_RST && s.cnt == TPC_CNT_TOP)
    |=> s.cnt == TPC_CNT_RST && s.counter_overflow_flag
  ) else $error("free-running wrap wrong");

  chk_mod_wrap: assert property (@(posedge core_clk)
    disable iff (reset)
    (adv && !s.cas && s.modv != TPC_MOD_RST && s.cnt == s.modv)
    |=> s.cnt == TPC_CNT_RST && s.counter_overflow_flag
  ) else $error("modulus wrap wrong");

  chk_center_turn: assert property (@(posedge core_clk)
    disable iff (reset)
    (adv && s.cas && s.up && s.cnt == limit)
    |=> !s.up && s.counter_overflow_flag && s.cnt == $past(s.cnt) - 16'h0001
  ) else $error("center mode turn wrong");

  chk_cnt_clear: assert property (@(posedge core_clk)
    disable iff (reset)
    cnt_clr |=> s.cnt == TPC_CNT_RST && s.pre == TPC_PRE_RST
  ) else $error("counter write did not clear counter and prescaler");

  chk_halt_freeze: assert property (@(posedge core_clk)
    disable iff (reset)
    (debug_halt_mode && !cnt_clr) |=> $stable(s.cnt)
  ) else $error("counter moved during debug halt");

  chk_tof_hold: assert property (@(posedge core_clk)
    disable iff (reset)
    (s.counter_overflow_flag && !(wr && hit_stat && s.tof_arm)) |=> s.counter_overflow_flag
  ) else $error("overflow flag cleared without two steps");
endmodule

// file: inc/tpc_pkg.sv
/*
  Shared constants for the sixteen-bit timer and PWM block: register
  offsets, field positions, reset values, source, mode and edge codes.
  Assumes an APB slave with 32-bit data and byte addresses.
*/
// Behaviour
// - Source select: none, bus, fixed, external
// - Bus clock source counts without synchroniser
// - Fixed clock synchronised only when loop engaged
// - External clock always synchronised to bus clock
// - Interrupt while overflow flag and enable set
// - Free run wraps 0xFFFF to 0, sets flag
// - Modulus wrap to zero sets overflow flag
// - Center mode turns at modulus, sets flag
// - Capture edge select sets channel flag, except in center mode
// - Output compare match sets channel flag
// - Edge PWM match marks duty end
// - Center PWM flags both duty matches
// - Channel flags cleared only by two steps
// - Counter write clears counter and prescaler
// - Debug halt freezes counter for reads
package tpc_pkg;
  localparam int TPC_NCH = 2;

  localparam logic [7:0] TPC_CTRL      = 8'h00;
  localparam logic [7:0] TPC_STAT      = 8'h04;
  localparam logic [7:0] TPC_MASK      = 8'h08;
  localparam logic [7:0] TPC_CNT       = 8'h0c;
  localparam logic [7:0] TPC_MOD       = 8'h10;
  localparam logic [7:0] TPC_CH_BASE   = 8'h14;
  localparam logic [7:0] TPC_CH_STEP   = 8'h08;
  localparam logic [7:0] TPC_CH_VALOFS = 8'h04;

  localparam int TPC_CTRL_CSS_LSB = 0;
  localparam int TPC_CTRL_PS_LSB  = 2;
  localparam int TPC_CTRL_CAS_BIT = 5;
  localparam int TPC_STAT_TOF_BIT = 0;
  localparam int TPC_STAT_CH_LSB  = 1;
  localparam int TPC_CHC_MODE_LSB = 0;
  localparam int TPC_CHC_EDGE_LSB = 2;

  localparam logic [1:0]  TPC_CSS_RST  = 2'h0;
  localparam logic [2:0]  TPC_PS_RST   = 3'h0;
  localparam logic [15:0] TPC_MOD_RST  = 16'h0000;
  localparam logic [15:0] TPC_CNT_RST  = 16'h0000;
  localparam logic [15:0] TPC_CNT_TOP  = 16'hffff;
  localparam logic [3:0]  TPC_CHC_RST  = 4'h0;
  localparam logic [6:0]  TPC_PRE_RST  = 7'h00;

  typedef enum logic [1:0] {
    TPC_SRC_NONE  = 2'b00,
    TPC_SRC_BUS   = 2'b01,
    TPC_SRC_FIXED = 2'b10,
    TPC_SRC_EXT   = 2'b11
  } tpc_src_t;

  typedef enum logic [1:0] {
    TPC_MODE_CAPT = 2'b00,
    TPC_MODE_CMP  = 2'b01,
    TPC_MODE_EPWM = 2'b10,
    TPC_MODE_OFF  = 2'b11
  } tpc_mode_t;

  typedef enum logic [1:0] {
    TPC_EDGE_OFF  = 2'b00,
    TPC_EDGE_RISE = 2'b01,
    TPC_EDGE_FALL = 2'b10,
    TPC_EDGE_ANY  = 2'b11
  } tpc_edge_t;
endpackage

// file: hdl/tpc_sync.sv
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes inputs are asynchronous levels; only stage two is read.
*/
`timescale 1ns/10ps
module tpc_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tpc_sync_st_t;
  tpc_sync_st_t s, next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.s2;
endmodule

// file: hdl/tpc_channel.sv
/*
  One timer channel: capture, compare and PWM, with its event flag.
  Assumes counter, advance strobe and synced pin from the timer core.
*/
`timescale 1ns/10ps
module tpc_channel (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [15:0] cnt,
  input  wire logic [15:0] cnt_next,
  input  wire logic        adv,
  input  wire logic        center,
  input  wire logic        pin_s,
  input  wire logic        wr_ctrl,
  input  wire logic        wr_val,
  input  wire logic [15:0] wdata,
  input  wire logic        arm_rd,
  input  wire logic        wr_zero,
  output logic      [3:0]  ctrl,
  output logic      [15:0] val,
  output logic             flag,
  output logic             pin_out,
  output logic             pin_oe
);
  import tpc_pkg::*;

  typedef struct packed {
    logic [3:0]  ctrl;
    logic [15:0] val;
    logic        flag;
    logic        arm;
    logic        pin_q;
    logic        out;
  } tpc_ch_st_t;
  tpc_ch_st_t s, next_s;

  tpc_mode_t mode;
  tpc_edge_t esel;
  logic      rise, fall, cap, match;

  assign mode  = tpc_mode_t'(s.ctrl[TPC_CHC_MODE_LSB+:2]);
  assign esel  = tpc_edge_t'(s.ctrl[TPC_CHC_EDGE_LSB+:2]);
  assign rise  = pin_s && !s.pin_q;
  assign fall  = !pin_s && s.pin_q;
  // Center mode overrides the per-channel mode for capture, match and pin_out; pin_oe still follows it
  assign cap   = !center && mode == TPC_MODE_CAPT &&
                 ((esel == TPC_EDGE_RISE && rise) ||
                  (esel == TPC_EDGE_FALL && fall) ||
                  (esel == TPC_EDGE_ANY && (rise || fall)));
  assign match = adv && cnt_next == s.val &&
                 (center || mode == TPC_MODE_CMP ||
                  mode == TPC_MODE_EPWM);

  always_comb begin
    next_s       = s;
    next_s.pin_q = pin_s;
    if (wr_ctrl) begin
      next_s.ctrl = wdata[3:0];
    end
    if (wr_val) begin
      next_s.val = wdata;
    end
    if (cap) begin
      next_s.val = cnt;
    end
    if (cap || match) begin
      next_s.flag = 1'b1;
    end else if (wr_zero && s.arm) begin
      next_s.flag = 1'b0;
    end
    if (arm_rd) begin
      next_s.arm = s.flag;
    end else if (wr_zero) begin
      next_s.arm = 1'b0;
    end
    if (center || mode == TPC_MODE_EPWM) begin
      if (adv) begin
        next_s.out = cnt_next < s.val;
      end
    end else if (mode == TPC_MODE_CMP) begin
      if (match) begin
        next_s.out = !s.out;
      end
    end else begin
      next_s.out = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ctrl    = s.ctrl;
  assign val     = s.val;
  assign flag    = s.flag;
  assign pin_out = s.out;
  // Edge select zero leaves the pin free for software compare
  assign pin_oe  = mode != TPC_MODE_CAPT && mode != TPC_MODE_OFF &&
                   esel != TPC_EDGE_OFF;

  chk_match_flag: assert property (@(posedge core_clk)
    disable iff (reset) match |=> s.flag
  ) else $error("compare match did not set flag");

  chk_capture_load: assert property (@(posedge core_clk)
    disable iff (reset) (cap && !wr_val) |=> s.flag && s.val == $past(cnt)
  ) else $error("capture did not load count and flag");

  chk_flag_hold: assert property (@(posedge core_clk)
    disable iff (reset) (s.flag && !(wr_zero && s.arm)) |=> s.flag
  ) else $error("channel flag cleared without two steps");
endmodule

// file: testbench/tpc_pins.sv
/*
  Far-side model: external count clock, fixed clock, channel pin levels.
  Assumes the bench sets ext_en and pin_lvl just after core_clk edges.
*/
`timescale 1ns/10ps
module tpc_pins (
  input  wire logic       ext_en,
  input  wire logic [1:0] pin_lvl,
  output logic            ext_clk_pin,
  output logic            fixed_clk,
  output logic      [1:0] ch_pin_in
);
  initial ext_clk_pin = 1'b0;
  initial fixed_clk = 1'b0;
  // 40 ns period: slower than a quarter of the 5 ns bus clock
  always #20 ext_clk_pin = ext_en ? ~ext_clk_pin : 1'b0;
  always #25 fixed_clk = ~fixed_clk;
  // Count clock has its own pin, never a channel pin
  assign ch_pin_in = pin_lvl;
endmodule

// file: testbench/tb.sv
/*
  Self-checking bench for the timer block: registers, sources, flags,
  channels. Assumes the pin model tpc_pins on the far side.
*/
`timescale 1ns/10ps
module tb;
  import tpc_pkg::*;
  typedef struct {
    logic [7:0]  a;
    logic        wr;
    logic [31:0] d;
    logic [31:0] exp;
    logic        err;
  } tpc_row_t;
  logic        core_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic        ext_clk_pin, fixed_clk, loop_engaged, debug_halt_mode;
  logic        irq, ext_en, erv;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rdv, v;
  logic [1:0]  ch_pin_in, ch_pin_out, ch_pin_oe, pin_lvl;
  int          fails = 0;
  int          tests_run = 0;
  int          cycles = 0;
  tpc_row_t rows [11] = '{
    '{TPC_CTRL, 1'b0, 32'h0, 32'h0, 1'b0},
    '{TPC_STAT, 1'b0, 32'h0, 32'h0, 1'b0},
    '{TPC_MASK, 1'b0, 32'h0, 32'h0, 1'b0},
    '{TPC_CNT, 1'b0, 32'h0, 32'h0, 1'b0},
    '{TPC_MOD, 1'b0, 32'h0, 32'h0, 1'b0},
    '{TPC_CTRL, 1'b1, 32'h3c, 32'h3c, 1'b0},
    '{TPC_MASK, 1'b1, 32'h7, 32'h7, 1'b0},
    '{TPC_MOD, 1'b1, 32'h1234, 32'h1234, 1'b0},
    '{8'h18, 1'b1, 32'hbeef, 32'hbeef, 1'b0},
    '{8'h1c, 1'b1, 32'hf, 32'hf, 1'b0},
    '{8'h40, 1'b1, 32'h5, 32'h0, 1'b1}};
  logic [31:0] s_ctl [6] = '{32'h0, 32'h1, 32'h9, 32'h2, 32'h2, 32'h3};
  logic        s_lp  [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [31:0] s_lo  [6] = '{32'h0, 32'h4e, 32'h13, 32'h4e, 32'h6, 32'h8};
  logic [31:0] s_hi  [6] = '{32'h0, 32'h56, 32'h16, 32'h56, 32'ha, 32'hc};

  tpc_top u_tpc_top (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_pin(ext_clk_pin), .fixed_clk(fixed_clk),
    .loop_engaged(loop_engaged), .debug_halt_mode(debug_halt_mode),
    .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
    .ch_pin_oe(ch_pin_oe), .irq(irq));
  tpc_pins u_tpc_pins (.ext_en(ext_en), .pin_lvl(pin_lvl),
    .ext_clk_pin(ext_clk_pin), .fixed_clk(fixed_clk),
    .ch_pin_in(ch_pin_in));

  always #2.5 core_clk = ~core_clk;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo,
                         input logic [31:0] hi);
    tests_run++;
    if ((got < lo) !== 1'b0 || (got > hi) !== 1'b0) begin
      fails++;
      $display("unexpected at %0t: got %h want %h..%h", $time, got, lo, hi);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'h3);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask

  task automatic clr();
    rd(TPC_STAT);
    wr(TPC_STAT, 32'h0);
  endtask

  task automatic hold(input logic on);
    debug_halt_mode <= on;
    @(posedge core_clk);
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails++;
      $display("timeout at %0t", $time);
      wrap_up();
    end
  end

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    ext_en = 1'b0;
    pin_lvl = 2'b00;
    loop_engaged = 1'b0;
    debug_halt_mode = 1'b0;
    repeat (16) @(posedge core_clk);
    chk({29'h0, irq, ch_pin_oe}, 32'h0);
    chk(prdata, 32'h0);
    reset <= 1'b0;
    @(posedge core_clk);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(rdv, rows[i].exp);
      chk({31'h0, erv}, {31'h0, rows[i].err});
    end
    wr(TPC_CTRL, 32'h0);
    wr(TPC_MOD, 32'h0);
    wr(TPC_MASK, 32'h0);
    wr(8'h1c, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      loop_engaged <= s_lp[i];
      ext_en <= (s_ctl[i] == 32'h3);
      wr(TPC_CTRL, s_ctl[i]);
      wr(TPC_CNT, 32'h0);
      repeat (80) @(posedge core_clk);
      hold(1'b1);
      rd(TPC_CNT);
      chk_rng(rdv, s_lo[i], s_hi[i]);
      hold(1'b0);
    end
    wr(TPC_CTRL, 32'h1);
    hold(1'b1);
    rd(TPC_CNT);
    v = rdv;
    repeat (20) @(posedge core_clk);
    rd(TPC_CNT);
    chk(rdv, v);
    hold(1'b0);
    // Divide by 128: a stale prescaler would tick within 60 cycles
    wr(TPC_CTRL, 32'h1d);
    repeat (100) @(posedge core_clk);
    apb(1'b1, TPC_CNT, 32'hffff, 4'h2);
    repeat (60) @(posedge core_clk);
    hold(1'b1);
    rd(TPC_CNT);
    chk(rdv, 32'h0);
    hold(1'b0);
    $display("test sources done");
    wr(TPC_CTRL, 32'h1);
    wr(TPC_MASK, 32'h1);
    wr(TPC_CNT, 32'h0);
    repeat (65400) @(posedge core_clk);
    rd(TPC_STAT);
    chk(rdv, 32'h0);
    repeat (200) @(posedge core_clk);
    rd(TPC_STAT);
    chk(rdv, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(TPC_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(TPC_CTRL, 32'h0);
    wr(TPC_STAT, 32'h1);
    wr(TPC_STAT, 32'h0);
    rd(TPC_STAT);
    chk(rdv, 32'h1);
    clr();
    rd(TPC_STAT);
    chk(rdv, 32'h0);
    $display("test overflow done");
    wr(TPC_MOD, 32'h9);
    wr(8'h14, 32'h5);
    wr(8'h18, 32'h5);
    wr(8'h1c, 32'h6);
    wr(8'h20, 32'h3);
    wr(TPC_CNT, 32'h0);
    wr(TPC_CTRL, 32'h1);
    repeat (30) @(posedge core_clk);
    wr(TPC_CTRL, 32'h0);
    rd(TPC_STAT);
    chk(rdv, 32'h7);
    chk({30'h0, ch_pin_oe}, 32'h3);
    rd(TPC_CNT);
    chk_rng(rdv, 32'h0, 32'h9);
    clr();
    wr(TPC_MOD, 32'h64);
    wr(8'h18, 32'h14);
    wr(8'h1c, 32'h3);
    wr(TPC_CNT, 32'h0);
    wr(TPC_CTRL, 32'h21);
    repeat (55) @(posedge core_clk);
    hold(1'b1);
    rd(TPC_STAT);
    chk(rdv, 32'h6);
    clr();
    hold(1'b0);
    repeat (60) @(posedge core_clk);
    hold(1'b1);
    rd(TPC_STAT);
    chk(rdv, 32'h1);
    hold(1'b0);
    repeat (70) @(posedge core_clk);
    hold(1'b1);
    rd(TPC_STAT);
    chk(rdv, 32'h3);
    rd(TPC_CNT);
    chk_rng(rdv, 32'h2, 32'h12);
    chk({30'h0, ch_pin_out}, 32'h1);
    hold(1'b0);
    wr(TPC_CTRL, 32'h0);
    $display("test channels done");
    clr();
    for (int e = 0; e < 4; e++) begin
      wr(8'h1c, 32'(e << 2));
      pin_lvl[1] <= 1'b1;
      repeat (8) @(posedge core_clk);
      rd(TPC_STAT);
      chk(rdv, {29'h0, e[0], 2'b00});
      clr();
      pin_lvl[1] <= 1'b0;
      repeat (8) @(posedge core_clk);
      rd(TPC_STAT);
      chk(rdv, {29'h0, e[1], 2'b00});
      clr();
    end
    $display("test capture done");
    wrap_up();
  end
endmodule
